// *** include/tmon_pkg.sv ***
/*
  shared constants, types and helpers of the temperature monitor control.
  assumes a 50 MHz system clock and an 8-bit register space.
*/
package tmon_pkg;
    // timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int CONV_PER_S      = 3;
    localparam int CHAN_MAX        = 5;
    localparam int SLOT_CYCLES_DEF = CLK_HZ / (CONV_PER_S * CHAN_MAX);
    localparam int SLOT_W          = 23;
    // command pointer values
    localparam logic [7:0] CMD_RESET        = 8'h00;
    localparam logic [7:0] CMD_STATUS1      = 8'h05;
    localparam logic [7:0] CMD_STATUS2      = 8'h06;
    localparam logic [7:0] CMD_CFG_RD       = 8'h07;
    localparam logic [7:0] CMD_LIM_RD_FIRST = 8'h08;
    localparam logic [7:0] CMD_CFG_WR       = 8'h12;
    localparam logic [7:0] CMD_LIM_WR_FIRST = 8'h13;
    localparam int         LIM_PER_CH       = 2;
    // config_control fields
    localparam int         CFG_MASK_ALL  = 7;
    localparam int         CFG_STANDBY   = 6;
    localparam int         CFG_MASK_R1   = 2;
    localparam int         CFG_BIAS_HIGH = 1;
    localparam int         CFG_BIAS_LOW  = 0;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] CFG_R34_MASKS = 8'h30;
    // status_summary fields
    localparam int ST1_BUSY        = 7;
    localparam int ST1_LOCAL_OVER  = 6;
    localparam int ST1_LOCAL_UNDER = 5;
    localparam int ST1_OPEN        = 4;
    localparam int ST1_ALARM       = 3;
    // register memory layout
    localparam int               IDX_W     = 4;
    localparam int               MEM_DEPTH = 16;
    localparam int               LIM_COUNT = 10;
    localparam logic [IDX_W-1:0] LIM_BASE  = 4'h5;
    localparam logic [7:0]       LIMIT_MAX = 8'h7f;
    localparam logic [7:0]       LIMIT_MIN = 8'h80;
    // addresses and straps
    localparam logic [6:0] ARA_ADDR    = 7'h0c;
    localparam logic [6:0] STRAP_B_GND = 7'h18;
    localparam logic [6:0] STRAP_B_HIZ = 7'h29;
    localparam logic [6:0] STRAP_B_VCC = 7'h4c;
    localparam logic [1:0] STRAP_GND   = 2'h0;
    localparam logic [1:0] STRAP_HIZ   = 2'h1;
    localparam logic [1:0] STRAP_VCC   = 2'h2;

    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CONV} conv_state_e;

    function automatic logic [IDX_W-1:0] limIdx(input logic [2:0] ch, input logic high);
        return LIM_BASE + {ch, 1'b0} + {3'h0, ~high};
    endfunction

    function automatic logic [IDX_W-1:0] ptrIdx(input logic [7:0] ptr, input logic [7:0] first);
        logic [7:0] off;
        off = ptr - first;
        return LIM_BASE + off[IDX_W-1:0];
    endfunction
endpackage

// *** include/regmem_if.sv ***
/*
  carrier between the control logic and its register memory.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface regmem_if import tmon_pkg::*; ();
    logic [IDX_W-1:0] hostIdx;
    logic             hostWe;
    logic [7:0]       hostWdata;
    logic             convWe;
    logic [IDX_W-1:0] convIdx;
    logic [7:0]       convWdata;
    logic [2:0]       limCh;
    logic [7:0]       rdData;
    logic [7:0]       limHi;
    logic [7:0]       limLo;
    modport ctrl (output hostIdx, hostWe, hostWdata, convWe, convIdx, convWdata, limCh,
                  input rdData, limHi, limLo);
    modport mem (input hostIdx, hostWe, hostWdata, convWe, convIdx, convWdata, limCh,
                 output rdData, limHi, limLo);
endinterface
`default_nettype wire

// *** design/strap_addr_latch.sv ***
/*
  samples the two three-state address straps after reset and latches the address.
  assumes strap codes 0 ground, 1 floating, 2 supply from the pin detectors.
*/
`timescale 1ns/100ps
`default_nettype none
module strap_addr_latch import tmon_pkg::*; (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // strap pins
    input  wire logic [1:0] strapA,
    input  wire logic [1:0] strapB,
    // latched address
    output logic [6:0]      slaveAddr,
    output logic            addrLatched
);
    localparam logic [1:0] FILL_FULL = 2'h3;

    typedef struct packed {
        logic [2:0][1:0] syncA;
        logic [2:0][1:0] syncB;
        logic [1:0]      fill;
        logic [6:0]      addr;
        logic            latched;
    } strap_s;

    strap_s r;
    strap_s n;

    function automatic logic [6:0] decode(input logic [1:0] a, input logic [1:0] b);
        logic [6:0] base;
        logic [1:0] off;
        off  = (b == STRAP_GND || b == STRAP_VCC) ? b : STRAP_HIZ;
        base = (a == STRAP_GND) ? STRAP_B_GND : (a == STRAP_VCC) ? STRAP_B_VCC : STRAP_B_HIZ;
        return base + {5'h00, off};
    endfunction

    always_comb begin
        n       = r;
        n.syncA = {r.syncA[1:0], strapA};
        n.syncB = {r.syncB[1:0], strapB};
        if (r.fill != FILL_FULL) begin
            n.fill = r.fill + 2'h1;
        end
        // latched once, later pin changes ignored
        if (!r.latched && r.fill == FILL_FULL && r.syncA[1] == r.syncA[2]
                && r.syncB[1] == r.syncB[2]) begin
            n.latched = 1'b1;
            n.addr    = decode(r.syncA[2], r.syncB[2]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign slaveAddr   = r.addr;
    assign addrLatched = r.latched;
endmodule
`default_nettype wire

// *** design/temp_reg_mem.sv ***
/*
  temperature and limit register memory with registered read data.
  assumes the controller never writes one index from both ports at once.
*/
`timescale 1ns/100ps
`default_nettype none
module temp_reg_mem import tmon_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // controller side
    regmem_if.mem    bus
);
    typedef struct packed {
        logic [MEM_DEPTH-1:0][7:0] arr;
        logic [7:0]                rdData;
        logic [7:0]                limHi;
        logic [7:0]                limLo;
    } mem_s;

    function automatic mem_s memInit();
        mem_s m;
        m = '0;
        for (int i = 0; i < LIM_COUNT; i++) begin
            m.arr[int'(LIM_BASE) + i] = (i % 2 == 0) ? LIMIT_MAX : LIMIT_MIN;
        end
        return m;
    endfunction

    localparam mem_s MEM_INIT = memInit();

    mem_s r;
    mem_s n;

    always_comb begin
        n = r;
        if (bus.hostWe) begin
            n.arr[bus.hostIdx] = bus.hostWdata;
        end
        if (bus.convWe) begin
            n.arr[bus.convIdx] = bus.convWdata;
        end
        n.rdData = r.arr[bus.hostIdx];
        n.limHi  = r.arr[limIdx(bus.limCh, 1'b1)];
        n.limLo  = r.arr[limIdx(bus.limCh, 1'b0)];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= MEM_INIT;
        end else begin
            r <= n;
        end
    end

    assign bus.rdData = r.rdData;
    assign bus.limHi  = r.limHi;
    assign bus.limLo  = r.limLo;
endmodule
`default_nettype wire

// *** design/multichannel_temp_monitor_ctrl.sv ***
/*
  control and status of a multichannel thermometer: conversion sequencing,
  configuration, sticky status, alert latch and slave address recognition.
  assumes a serial framing layer on the same clock that hands over decoded
  addresses, command bytes, write bytes and read requests as one-cycle strobes,
  and a converter on the same clock that answers each start with one done pulse.
*/
// What this block does
// - convert all channels continuously, store each result
// - one shared slave address from two straps
// - nine-entry strap to address decode
// - straps sampled after reset, address then frozen
// - also answer the alert response address while the alert latch is set
// - reset clears every volatile register except the limits
// - no conversion start during undervoltage lockout
// - reset clears alert latch, converting starts unasked
// - command pointer resets to local temperature
// - limits reset to maximum and minimum
// - global mask suppresses the alert output
// - standby bit stops conversions at once
// - per-remote mask bits block their alerts
// - bias low or medium from bit zero
// - bit one forces high bias
// - summary bit seven shows conversion busy
// - summary bits six, five: local over, under
// - summary bit four open, three remote alarm
// - summary flags sticky until reset or read
// - remote byte holds under/over pairs per channel
// - remote alarm flags sticky until reset or read
// - two-remote variant drops channels three, four
// - read clears flags, persisting faults set again
// - flag clearing leaves alert latch alone
// - alert response read returns address, clears latch
`timescale 1ns/100ps
`default_nettype none
module multichannel_temp_monitor_ctrl import tmon_pkg::*; #(
    parameter int REMOTE_COUNT = 4,
    parameter int SLOT_CYCLES  = SLOT_CYCLES_DEF
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // address straps
    input  wire logic [1:0] strapA,
    input  wire logic [1:0] strapB,
    // serial framing side
    input  wire logic       frameValid,
    input  wire logic [6:0] frameAddr,
    input  wire logic       cmdStrobe,
    input  wire logic [7:0] cmdByte,
    input  wire logic       wrStrobe,
    input  wire logic [7:0] wrData,
    input  wire logic       rdStrobe,
    output logic            addrAck,
    output logic            rdValid,
    output logic [7:0]      rdData,
    // converter side
    input  wire logic       uvloPin,
    input  wire logic       convDone,
    input  wire logic [7:0] convResult,
    input  wire logic       openFault,
    output logic            convStart,
    output logic [2:0]      convChan,
    output logic            convRun,
    output logic            biasHigh,
    output logic            biasLow,
    output logic            biasMed,
    // alert pin, driven low while enabled
    output logic            alertOe
);
    localparam logic [2:0]        CHAN_LAST   = 3'(REMOTE_COUNT);
    localparam logic [7:0]        TEMP_RD_END = 8'(REMOTE_COUNT);
    localparam logic [7:0]        LIM_SPAN    = 8'(LIM_PER_CH * (REMOTE_COUNT + 1) - 1);
    localparam logic [7:0]        LIM_RD_END  = CMD_LIM_RD_FIRST + LIM_SPAN;
    localparam logic [7:0]        LIM_WR_END  = CMD_LIM_WR_FIRST + LIM_SPAN;
    localparam logic [7:0]        CFG_KEEP    = (REMOTE_COUNT < 3) ? ~CFG_R34_MASKS : '1;
    localparam logic [SLOT_W-1:0] SLOT_LOAD   = SLOT_W'(SLOT_CYCLES - 1);
    typedef struct packed {
        conv_state_e       state;
        logic [SLOT_W-1:0] slot;
        logic [2:0]        chan;
        logic [7:0]        cmdPtr;
        logic [7:0]        cfg;
        logic [2:0]        uvloSync;
        logic              uvloAct;
        logic [4:0]        condOver;
        logic [4:0]        condUnder;
        logic              openCond;
        logic              localOver;
        logic              localUnder;
        logic              openFlag;
        logic              remoteAlarm;
        logic [7:0]        st2;
        logic              alertLatch;
        logic              araSel;
        logic              rdPend;
        logic              rdFromMem;
        logic [7:0]        hold;
        logic              addrAck;
        logic              rdValid;
        logic [7:0]        rdData;
        logic              convStart;
        logic [2:0]        convChan;
        logic              convRun;
        logic              biasHigh;
        logic              biasLow;
        logic              biasMed;
        logic              alertOe;
    } ctrl_s;
    ctrl_s r;
    ctrl_s n;
    logic [6:0] slaveAddr;
    logic       addrLatched;
    logic       rd1;
    logic       rd2;
    logic       araDone;
    logic       convHold;
    logic       doneNow;
    logic       overNow;
    logic       underNow;
    logic       chanMasked;
    logic       alertSet;
    logic       wrLimit;
    logic       rdLimit;
    logic       rdTemp;
    regmem_if memBus ();
    strap_addr_latch u_strap (
        .clk         (clk),
        .rstn        (rstn),
        .strapA      (strapA),
        .strapB      (strapB),
        .slaveAddr   (slaveAddr),
        .addrLatched (addrLatched)
    );

    temp_reg_mem u_mem (
        .clk  (clk),
        .rstn (rstn),
        .bus  (memBus)
    );
    function automatic logic [7:0] st2Pack(input logic [4:0] over, input logic [4:0] under);
        logic [7:0] v;
        v = '0;
        for (int c = 1; c <= 4; c++) begin
            v[9 - 2 * c] = under[c];
            v[8 - 2 * c] = over[c];
        end
        return v;
    endfunction
    // request decode
    assign rd1        = rdStrobe && !r.araSel && r.cmdPtr == CMD_STATUS1;
    assign rd2        = rdStrobe && !r.araSel && r.cmdPtr == CMD_STATUS2;
    assign araDone    = rdStrobe && r.araSel;
    assign wrLimit    = r.cmdPtr >= CMD_LIM_WR_FIRST && r.cmdPtr <= LIM_WR_END;
    assign rdLimit    = r.cmdPtr >= CMD_LIM_RD_FIRST && r.cmdPtr <= LIM_RD_END;
    assign rdTemp     = r.cmdPtr <= TEMP_RD_END;
    // conversion result checks
    assign convHold   = r.cfg[CFG_STANDBY] || r.uvloAct || !addrLatched;
    assign doneNow    = r.state == S_CONV && convDone && !convHold;
    assign overNow    = $signed(convResult) > $signed(memBus.limHi);
    assign underNow   = $signed(convResult) < $signed(memBus.limLo);
    assign chanMasked = r.chan != 3'h0 && r.cfg[CFG_MASK_R1 + int'(r.chan) - 1];
    assign alertSet   = doneNow && (overNow || underNow) && !chanMasked;

    always_comb begin
        n              = r;
        n.convStart    = 1'b0;
        n.addrAck      = 1'b0;
        memBus.hostWe    = 1'b0;
        memBus.hostWdata = wrData;
        memBus.convWe    = 1'b0;
        memBus.convIdx   = {1'b0, r.chan};
        memBus.convWdata = convResult;
        memBus.limCh     = r.chan;
        if (wrStrobe && wrLimit) begin
            memBus.hostIdx = ptrIdx(r.cmdPtr, CMD_LIM_WR_FIRST);
        end else if (rdLimit) begin
            memBus.hostIdx = ptrIdx(r.cmdPtr, CMD_LIM_RD_FIRST);
        end else begin
            memBus.hostIdx = r.cmdPtr[IDX_W-1:0];
        end
        // address recognition
        if (frameValid) begin
            n.addrAck = addrLatched && (frameAddr == slaveAddr
                        || (frameAddr == ARA_ADDR && r.alertLatch));
            n.araSel  = addrLatched && frameAddr == ARA_ADDR && r.alertLatch;
        end else if (araDone) begin
            n.araSel = 1'b0;
        end
        // command pointer and writes
        if (cmdStrobe) begin
            n.cmdPtr = cmdByte;
        end
        if (wrStrobe) begin
            if (r.cmdPtr == CMD_CFG_WR) begin
                n.cfg = wrData & CFG_KEEP;
            end else if (wrLimit) begin
                memBus.hostWe = 1'b1;
            end
        end
        // reads, answered two cycles after the strobe
        n.rdPend  = rdStrobe;
        n.rdValid = r.rdPend;
        if (r.rdPend) begin
            n.rdData = r.rdFromMem ? memBus.rdData : r.hold;
        end
        if (rdStrobe) begin
            n.rdFromMem = 1'b0;
            n.hold      = '0;
            if (r.araSel) begin
                n.hold = {slaveAddr, 1'b0};
            end else if (rdTemp || rdLimit) begin
                n.rdFromMem = 1'b1;
            end else if (r.cmdPtr == CMD_STATUS1) begin
                n.hold[ST1_BUSY]        = r.state == S_CONV;
                n.hold[ST1_LOCAL_OVER]  = r.localOver;
                n.hold[ST1_LOCAL_UNDER] = r.localUnder;
                n.hold[ST1_OPEN]        = r.openFlag;
                n.hold[ST1_ALARM]       = r.remoteAlarm;
            end else if (r.cmdPtr == CMD_STATUS2) begin
                n.hold = r.st2;
            end else if (r.cmdPtr == CMD_CFG_RD) begin
                n.hold = r.cfg;
            end
        end
        // lockout input synchroniser
        n.uvloSync = {r.uvloSync[1:0], uvloPin};
        if (r.uvloSync[1] == r.uvloSync[2]) begin
            n.uvloAct = r.uvloSync[2];
        end
        // conversion sequencing
        case (r.state)
            S_IDLE: begin
                if (!convHold) begin
                    n.state = S_CONV;
                end
            end
            S_WAIT: begin
                if (convHold) begin
                    n.state = S_IDLE;
                end else if (r.slot == '0) begin
                    n.state = S_CONV;
                end else begin
                    n.slot = r.slot - 1'b1;
                end
            end
            S_CONV: begin
                if (convHold) begin
                    n.state = S_IDLE;
                end else if (convDone) begin
                    memBus.convWe          = 1'b1;
                    n.condOver[r.chan]     = overNow;
                    n.condUnder[r.chan]    = underNow;
                    n.chan  = (r.chan == CHAN_LAST) ? 3'h0 : r.chan + 3'h1;
                    n.slot  = SLOT_LOAD;
                    n.state = S_WAIT;
                end
            end
            default: begin
                n.state = S_IDLE;
            end
        endcase
        if (r.state != S_CONV && n.state == S_CONV) begin
            n.convStart = 1'b1;
            n.convChan  = r.chan;
            if (r.chan != 3'h0) begin
                n.openCond = openFault;
            end
        end
        n.convRun = n.state != S_IDLE;
        // sticky status, a persisting condition sets its flag again
        n.localOver   = (r.localOver && !rd1) || r.condOver[0];
        n.localUnder  = (r.localUnder && !rd1) || r.condUnder[0];
        n.openFlag    = (r.openFlag && !rd1) || r.openCond;
        n.remoteAlarm = (r.remoteAlarm && !rd1)
                        || (|r.condOver[4:1]) || (|r.condUnder[4:1]);
        n.st2 = (rd2 ? 8'h00 : r.st2) | st2Pack(r.condOver, r.condUnder);
        // alert latch, untouched by status reads
        n.alertLatch = (r.alertLatch && !araDone) || alertSet;
        n.alertOe    = r.alertLatch && !r.cfg[CFG_MASK_ALL];
        // diode bias
        n.biasHigh = r.cfg[CFG_BIAS_HIGH];
        n.biasLow  = !r.cfg[CFG_BIAS_HIGH] && r.cfg[CFG_BIAS_LOW];
        n.biasMed  = !r.cfg[CFG_BIAS_HIGH] && !r.cfg[CFG_BIAS_LOW];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign addrAck   = r.addrAck;
    assign rdValid   = r.rdValid;
    assign rdData    = r.rdData;
    assign convStart = r.convStart;
    assign convChan  = r.convChan;
    assign convRun   = r.convRun;
    assign biasHigh  = r.biasHigh;
    assign biasLow   = r.biasLow;
    assign biasMed   = r.biasMed;
    assign alertOe   = r.alertOe;
    // checks
    sequence s_ara_read;
        rdStrobe && r.araSel;
    endsequence
    sequence s_ara_answer;
        rdValid && rdData == {slaveAddr, 1'b0};
    endsequence
    property p_ptr_por;
        @(posedge clk) !rstn |=> (r.cmdPtr == CMD_RESET && r.cfg == CFG_RESET && !r.alertLatch);
    endproperty
    a_ptr_por: assert property (p_ptr_por) else $error("pointer not cleared by reset");
    property p_addr_frozen;
        @(posedge clk) disable iff (!rstn) addrLatched |=> $stable(slaveAddr);
    endproperty
    a_addr_frozen: assert property (p_addr_frozen) else $error("address moved");
    property p_uvlo_hold;
        @(posedge clk) disable iff (!rstn) r.uvloAct |=> !convStart;
    endproperty
    a_uvlo_hold: assert property (p_uvlo_hold) else $error("start in lockout");
    property p_standby;
        @(posedge clk) disable iff (!rstn) r.cfg[CFG_STANDBY] |=> (!convStart && r.state == S_IDLE);
    endproperty
    a_standby: assert property (p_standby) else $error("conversion in standby");
    property p_mask_all;
        @(posedge clk) disable iff (!rstn) r.cfg[CFG_MASK_ALL] |=> !alertOe;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("alert not masked");
    property p_bias;
        @(posedge clk) disable iff (!rstn)
            r.cfg[CFG_BIAS_HIGH] |=> (biasHigh && !biasLow && !biasMed);
    endproperty
    a_bias: assert property (p_bias) else $error("high bias not forced");
    property p_busy_read;
        @(posedge clk) disable iff (!rstn)
            (rd1 && r.state == S_CONV) |-> ##2 (rdValid && rdData[ST1_BUSY]);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy bit missing");
    property p_read_clear;
        @(posedge clk) disable iff (!rstn) (rd1 && !r.condOver[0]) |=> !r.localOver;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared");
    property p_sticky;
        @(posedge clk) disable iff (!rstn) (r.localOver && !rd1) |=> r.localOver;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_ara;
        @(posedge clk) disable iff (!rstn) s_ara_read |-> ##2 s_ara_answer;
    endproperty
    a_ara: assert property (p_ara) else $error("bad alert response");
    property p_ara_clear;
        @(posedge clk) disable iff (!rstn) (s_ara_read and !alertSet) |=> !r.alertLatch;
    endproperty
    a_ara_clear: assert property (p_ara_clear) else $error("latch not cleared");
    property p_remote_mask;
        @(posedge clk) disable iff (!rstn)
            (doneNow && r.chan == 3'h1 && r.cfg[CFG_MASK_R1] && !r.alertLatch) |=> !r.alertLatch;
    endproperty
    a_remote_mask: assert property (p_remote_mask) else $error("masked alert set");
endmodule
`default_nettype wire

// *** verif/conv_model.sv ***
/* converter stand-in: answers each start with one done pulse.
   assumes the monitor's clock; result is garbage outside done. */
`timescale 1ns/100ps
`default_nettype none
module conv_model (
    // clock
    input  wire logic       clk,
    // converter port
    input  wire logic       convStart,
    input  wire logic [7:0] temp,
    output logic            convDone,
    output logic [7:0]      convResult
);
    logic [2:0] cnt = 3'h0;
    assign convDone   = (cnt == 3'h1);
    assign convResult = convDone ? temp : ~temp;
    always_ff @(posedge clk) begin
        cnt <= (convStart === 1'b1) ? 3'h3 : (cnt != 3'h0) ? cnt - 3'h1 : cnt;
    end
endmodule
`default_nettype wire

// *** verif/multichannel_temp_monitor_ctrl_tb.sv ***
/* bench for the monitor control: host tasks over the register strobes.
   assumes conv_model on the converter port. */
`timescale 1ns/100ps
`default_nettype none
module multichannel_temp_monitor_ctrl_tb;
    import tmon_pkg::*;
    logic       clk = 0, rstn = 0, frameValid = 0, cmdStrobe = 0, wrStrobe = 0, rdStrobe = 0;
    logic [1:0] strapA = STRAP_GND, strapB = STRAP_HIZ;
    logic [6:0] frameAddr = 7'h00;
    logic [7:0] cmdByte = 8'h00, wrData = 8'h00, temp = 8'h00, got, rdData, convResult;
    logic       addrAck, rdValid, convDone, convStart, convRun, biasHigh, biasLow, biasMed, alertOe;
    logic [2:0] convChan;
    logic       uvlo = 0, fault = 0;
    int         err_total = 0, n_tests = 0;
    multichannel_temp_monitor_ctrl #(.REMOTE_COUNT(4), .SLOT_CYCLES(20))
    multichannel_temp_monitor_ctrl_inst (.clk, .rstn, .strapA, .strapB, .frameValid,
        .frameAddr, .cmdStrobe, .cmdByte, .wrStrobe, .wrData, .rdStrobe, .addrAck, .rdValid,
        .rdData, .uvloPin(uvlo), .convDone, .convResult, .openFault(fault), .convStart,
        .convChan, .convRun, .biasHigh, .biasLow, .biasMed, .alertOe);
    conv_model conv_model_inst (.clk, .convStart, .temp, .convDone, .convResult);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // kind 0 command, 1 write, 2 read, 3 address
    task automatic pulse(input int k, input logic [7:0] v);
        @(posedge clk);
        cmdStrobe  <= (k == 0);
        wrStrobe   <= (k == 1);
        rdStrobe   <= (k == 2);
        frameValid <= (k == 3);
        cmdByte    <= v;
        wrData     <= v;
        frameAddr  <= v[6:0];
        @(posedge clk);
        {cmdStrobe, wrStrobe, rdStrobe, frameValid} <= 4'h0;
    endtask
    task automatic rd(input logic cmd, input logic [7:0] p);
        int i;
        if (cmd) pulse(0, p);
        pulse(2, 8'h00);
        for (i = 0; i < 4 && rdValid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (rdValid !== 1'b1) begin
            err_total++;
            test_done();
        end
        got = rdData;
    endtask
    task automatic conv();
        int i;
        for (int k = 0; k < 2; k++) begin
            for (i = 0; i < 500 && !(convStart === 1'b1 && convChan === k[2:0]); i++) begin
                @(posedge clk);
                #1;
            end
            if (i == 500) begin
                err_total++;
                test_done();
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1;
        repeat (10) @(posedge clk);
        rd(0, 8'h00);
        check("ptr", got, 8'h00);
        rd(1, CMD_CFG_RD);
        check("cfg", got, CFG_RESET);
        for (int p = 8; p < 18; p++) begin
            rd(1, p[7:0]);
            check("limit", got, p[0] ? LIMIT_MIN : LIMIT_MAX);
        end
        pulse(3, 8'h19);
        #1 check("ack", {7'h0, addrAck}, 8'h01);
        pulse(3, 8'h18);
        #1 check("nack", {7'h0, addrAck}, 8'h00);
        strapA <= STRAP_VCC;
        pulse(3, 8'h19);
        #1 check("held", {7'h0, addrAck}, 8'h01);
        temp <= 8'h20;
        pulse(0, CMD_LIM_WR_FIRST);
        pulse(1, 8'h10);
        conv();
        rd(1, CMD_STATUS1);
        check("over", got & 8'h7f, 8'h40);
        check("alert", {7'h0, alertOe}, 8'h01);
        temp <= 8'h00;
        conv();
        rd(1, CMD_STATUS1);
        check("sticky", got & 8'h7f, 8'h40);
        rd(0, 8'h00);
        check("clear", got & 8'h7f, 8'h00);
        check("latch", {7'h0, alertOe}, 8'h01);
        pulse(0, CMD_CFG_WR);
        pulse(1, 8'h80);
        repeat (2) @(posedge clk);
        #1 check("mask all", {7'h0, alertOe}, 8'h00);
        pulse(0, CMD_CFG_WR);
        pulse(1, 8'h00);
        pulse(3, {1'b0, ARA_ADDR});
        #1 check("ara", {7'h0, addrAck}, 8'h01);
        rd(0, 8'h00);
        check("own", got, 8'h32);
        check("freed", {7'h0, alertOe}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            pulse(0, CMD_CFG_WR);
            pulse(1, 8'h42 - i[7:0]);
            repeat (2) @(posedge clk);
            #1 check("bias", {5'h0, biasHigh, biasLow, biasMed}, 8'h04 >> i);
        end
        check("stop", {7'h0, convRun}, 8'h00);
        rd(1, CMD_CFG_RD);
        check("keep", got, 8'h40);
        @(posedge clk);
        rstn <= 0;
        uvlo <= 1;
        repeat (4) @(posedge clk);
        rstn <= 1;
        repeat (12) @(posedge clk);
        #1 check("lockout", {7'h0, convRun}, 8'h00);
        pulse(3, 8'h4d);
        #1 check("resample", {7'h0, addrAck}, 8'h01);
        rd(1, CMD_CFG_RD);
        check("por cfg", got, CFG_RESET);
        rd(1, CMD_LIM_RD_FIRST);
        check("por limit", got, LIMIT_MAX);
        pulse(0, CMD_CFG_WR);
        pulse(1, 8'h04);
        pulse(0, 8'h16);
        pulse(1, 8'h30);
        {uvlo, fault} <= 2'h1;
        conv();
        repeat (8) @(posedge clk);
        rd(1, CMD_STATUS2);
        check("remote", got, 8'h80);
        rd(1, CMD_STATUS1);
        check("open", got & 8'h7f, 8'h18);
        check("masked", {7'h0, alertOe}, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
